// ---- hw/sdc_pkg.sv ----
package sdc_pkg;
    // Format modes selected by the two format pins
    localparam logic [1:0] MODE_DAC16  = 2'h0;
    localparam logic [1:0] MODE_DAC18  = 2'h1;
    localparam logic [1:0] MODE_DSP    = 2'h2;
    localparam logic [1:0] MODE_I2S    = 2'h3;
    // Word geometry
    localparam int         WORD_BITS   = 18;
    localparam int         SHORT_BITS  = 16;
    localparam int         CNT_W       = 6;
    // Master and filter clock to word rate ratios
    localparam int         RATIO_LO    = 256;
    localparam int         RATIO_HI    = 384;
    localparam int         FILT_RATIO  = 128;
    // Frame counts
    localparam int         CAL_FRAMES  = 1024;
    localparam int         PIPE_FRAMES = 33;
    localparam int         MUTE_FRAMES = 4096;
    localparam int         FRM_W       = 13;
    // Bus
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_LEFT   = 8'h04;
    localparam logic [7:0] ADDR_RIGHT  = 8'h08;
endpackage

// ---- hw/sdc_top.sv ----
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Master clock is 256x or 384x word rate
// - Filter clock output runs at 128x word rate
// - Frame clock kick-start starts filter clock
// - Two format pins pick modes 0 to 3
// - Modes 0,1 right-justified 16 and 18 bit
// - Mode 3 I2S, mode 2 DSP style
// - Modes 2,3 carry 18 bits or 16+00
// - Words are MSB first, two's complement
// - Short 16-clock words work in modes 0,2,3
// - Sample rising edge, falling in mode 2
// - Reset clears datapath, resyncs to frame clock
// - Calibration flag high from reset to done
// - Calibration lasts 1024 word periods
// - Outputs forced to zero while calibrating
// - Hold reset at power-up; release calibrates
// - Calibration-mute input mutes immediately
// - Zeros reach output after 33 frames; 4096 deep-mutes
// - Non-zero data releases deep mute at once
// - Format pins read as mode 0 until synchronised after reset
// - Calibration-mute low unmutes output stage
module sdc_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_ratio_sel,
    input  wire logic        fmt_sel_lo,
    input  wire logic        fmt_sel_hi,
    input  wire logic        factory_test_pin,
    input  wire logic        serial_bit_clk,
    input  wire logic        channel_frame_clk,
    input  wire logic        serial_sample_in,
    input  wire logic        cal_mute_in,
    input  wire logic        comparator_in,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             filter_clk_out,
    output logic             cal_active_out,
    output logic             comparator_out,
    output logic             out_zero,
    output logic             out_soft_mute,
    output logic             out_deep_mute,
    output logic      [17:0] sample_left,
    output logic      [17:0] sample_right,
    output logic             sample_valid
);
    localparam int W = sdc_pkg::WORD_BITS;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] s_bck, s_lrk, s_dat, s_cmute, s_cmp, s_f0, s_f1, s_cks;
    logic [1:0] next_s_bck, next_s_lrk, next_s_dat, next_s_cmute;
    logic [1:0] next_s_cmp, next_s_f0, next_s_f1, next_s_cks;
    logic       bck_d, lrk_d;
    logic       next_bck_d, next_lrk_d;
    logic [2:0] warm, next_warm;

    always_comb begin
        next_s_bck   = {s_bck[0], serial_bit_clk};
        next_s_lrk   = {s_lrk[0], channel_frame_clk};
        next_s_dat   = {s_dat[0], serial_sample_in};
        next_s_cmute = {s_cmute[0], cal_mute_in};
        next_s_cmp   = {s_cmp[0], comparator_in};
        next_s_f0    = {s_f0[0], fmt_sel_lo};
        next_s_f1    = {s_f1[0], fmt_sel_hi};
        next_s_cks   = {s_cks[0], clk_ratio_sel};
        next_bck_d   = s_bck[1];
        next_lrk_d   = s_lrk[1];
        next_warm    = {warm[1:0], 1'b1};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_bck   <= 2'h0;
            s_lrk   <= 2'h0;
            s_dat   <= 2'h0;
            s_cmute <= 2'h0;
            s_cmp   <= 2'h0;
            s_f0    <= 2'h0;
            s_f1    <= 2'h0;
            s_cks   <= 2'h0;
            bck_d   <= 1'b0;
            lrk_d   <= 1'b0;
            warm    <= 3'h0;
        end else begin
            s_bck   <= next_s_bck;
            s_lrk   <= next_s_lrk;
            s_dat   <= next_s_dat;
            s_cmute <= next_s_cmute;
            s_cmp   <= next_s_cmp;
            s_f0    <= next_s_f0;
            s_f1    <= next_s_f1;
            s_cks   <= next_s_cks;
            bck_d   <= next_bck_d;
            lrk_d   <= next_lrk_d;
            warm    <= next_warm;
        end
    end

    logic [1:0] mode;
    logic       bck_rise, bck_fall, take, frame_edge, lr_level;
    assign mode       = {s_f1[1], s_f0[1]};
    // No edges until the synchronisers hold real pin levels after reset
    assign bck_rise   = warm[2] & s_bck[1] & ~bck_d;
    assign bck_fall   = warm[2] & ~s_bck[1] & bck_d;
    assign take       = (mode == sdc_pkg::MODE_DSP) ? bck_fall
                                                    : bck_rise;
    assign frame_edge = warm[2] & (s_lrk[1] ^ lrk_d);
    // Left channel while frame clock high, inverted for I2S
    assign lr_level   = (mode == sdc_pkg::MODE_I2S) ? ~s_lrk[1]
                                                    : s_lrk[1];

    ////////////////////////////////////////////////////////////////////////
    // Filter clock divider
    logic [1:0] div_cnt;
    logic [1:0] next_div_cnt;
    logic       next_filt;
    logic       filt_run;
    logic       next_filt_run;

    always_comb begin
        next_filt_run = filt_run | frame_edge;
        next_div_cnt  = div_cnt;
        next_filt     = filter_clk_out;
        if (filt_run) begin
            // 256x: toggle every cycle; 384x: toggle every 1.5 -> 2 of 3
            if (s_cks[1]) begin
                next_div_cnt = (div_cnt == 2'h2) ? 2'h0 : div_cnt + 2'h1;
                next_filt    = (div_cnt == 2'h0) | (div_cnt == 2'h2 &
                               ~filter_clk_out) ? ~filter_clk_out
                                                : filter_clk_out;
            end else begin
                next_div_cnt = 2'h0;
                next_filt    = ~filter_clk_out;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt        <= 2'h0;
            filter_clk_out <= 1'b0;
            filt_run       <= 1'b0;
        end else begin
            div_cnt        <= next_div_cnt;
            filter_clk_out <= next_filt;
            filt_run       <= next_filt_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial receiver
    logic [W-1:0]                 shreg, next_shreg;
    logic [sdc_pkg::CNT_W-1:0]    bcnt, next_bcnt;
    logic                         cur_lr, next_cur_lr;
    logic [W-1:0]                 word, left_w, right_w;
    logic [W-1:0]                 next_left, next_right;
    logic                         next_valid, word_done;
    logic                         synced, next_synced;

    // Right-justified modes use the last bits; others the first
    always_comb begin
        word = shreg;
        if (mode == sdc_pkg::MODE_DAC16)
            word = {shreg[sdc_pkg::SHORT_BITS-1:0], 2'h0};
        else if (mode != sdc_pkg::MODE_DAC18 &&
                 bcnt == sdc_pkg::CNT_W'(sdc_pkg::SHORT_BITS))
            word = {shreg[sdc_pkg::SHORT_BITS-1:0], 2'h0};
    end

    always_comb begin
        next_shreg  = shreg;
        next_bcnt   = bcnt;
        next_cur_lr = cur_lr;
        next_left   = sample_left;
        next_right  = sample_right;
        next_valid  = 1'b0;
        next_synced = synced;
        word_done   = 1'b0;
        if (take) begin
            if (lr_level != cur_lr) begin
                // Channel boundary: close out previous word
                word_done   = synced;
                next_synced = 1'b1;
                next_cur_lr = lr_level;
                next_bcnt   = sdc_pkg::CNT_W'(1);
                next_shreg  = {{(W-1){1'b0}}, s_dat[1]};
            end else begin
                if (bcnt < sdc_pkg::CNT_W'(W) ||
                    mode == sdc_pkg::MODE_DAC16 ||
                    mode == sdc_pkg::MODE_DAC18)
                    next_shreg = {shreg[W-2:0], s_dat[1]};
                if (bcnt != {sdc_pkg::CNT_W{1'b1}})
                    next_bcnt = bcnt + sdc_pkg::CNT_W'(1);
            end
            if (word_done) begin
                if (cur_lr)
                    next_left = word;
                else begin
                    next_right = word;
                    next_valid = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shreg        <= '0;
            bcnt         <= '0;
            cur_lr       <= 1'b0;
            synced       <= 1'b0;
            sample_left  <= '0;
            sample_right <= '0;
            sample_valid <= 1'b0;
        end else begin
            shreg        <= next_shreg;
            bcnt         <= next_bcnt;
            cur_lr       <= next_cur_lr;
            synced       <= next_synced;
            sample_left  <= next_left;
            sample_right <= next_right;
            sample_valid <= next_valid;
        end
    end
    assign left_w  = sample_left;
    assign right_w = sample_right;

    ////////////////////////////////////////////////////////////////////////
    // Calibration, zero detection, mutes
    logic [sdc_pkg::FRM_W-1:0] cal_cnt, next_cal_cnt;
    logic [sdc_pkg::FRM_W-1:0] zero_cnt, next_zero_cnt;
    logic                      next_cal, next_zero, next_deep, next_soft;
    logic                      next_cmp, frame_tick;
    logic                      zero_frame;

    assign frame_tick = sample_valid;
    assign zero_frame = (left_w == '0) && (right_w == '0);

    always_comb begin
        next_cal_cnt  = cal_cnt;
        next_cal      = cal_active_out;
        next_zero_cnt = zero_cnt;
        next_deep     = out_deep_mute;
        next_zero     = out_zero;
        next_cmp      = s_cmp[1];
        // Reset raised the flag; count frames from release
        if (cal_active_out && frame_tick) begin
            if (cal_cnt == sdc_pkg::FRM_W'(sdc_pkg::CAL_FRAMES - 1))
                next_cal = 1'b0;
            next_cal_cnt = cal_cnt + sdc_pkg::FRM_W'(1);
        end
        if (frame_tick) begin
            if (!zero_frame) begin
                next_zero_cnt = '0;
                next_deep     = 1'b0;
            end else if (zero_cnt !=
                         sdc_pkg::FRM_W'(sdc_pkg::MUTE_FRAMES)) begin
                next_zero_cnt = zero_cnt + sdc_pkg::FRM_W'(1);
                if (zero_cnt ==
                    sdc_pkg::FRM_W'(sdc_pkg::MUTE_FRAMES - 1))
                    next_deep = 1'b1;
            end
            // Output silent once zeros have filled the pipeline
            next_zero = zero_cnt >=
                        sdc_pkg::FRM_W'(sdc_pkg::PIPE_FRAMES - 1);
        end
        next_soft = s_cmute[1];
        if (next_cal)
            next_zero = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_cnt        <= '0;
            cal_active_out <= 1'b1;
            zero_cnt       <= '0;
            out_deep_mute  <= 1'b0;
            out_zero       <= 1'b1;
            out_soft_mute  <= 1'b0;
            comparator_out <= 1'b0;
        end else begin
            cal_cnt        <= next_cal_cnt;
            cal_active_out <= next_cal;
            zero_cnt       <= next_zero_cnt;
            out_deep_mute  <= next_deep;
            out_zero       <= next_zero;
            out_soft_mute  <= next_soft;
            comparator_out <= next_cmp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite status slave (read-only, zero wait)
    logic        next_ph_rd;
    logic [7:0]  next_ph_addr;
    logic [31:0] next_hrdata;

    always_comb begin
        next_ph_rd   = hsel & hready & (htrans == sdc_pkg::HTRANS_NSEQ)
                       & ~hwrite;
        next_ph_addr = haddr[7:0];
        next_hrdata  = 32'h0000_0000;
        if (next_ph_rd) begin
            unique case (next_ph_addr)
                sdc_pkg::ADDR_STATUS:
                    next_hrdata = {23'h0, factory_test_pin & 1'b0,
                                   mode, out_deep_mute, out_zero,
                                   out_soft_mute, filt_run,
                                   cal_active_out, synced};
                sdc_pkg::ADDR_LEFT:  next_hrdata = {14'h0, left_w};
                sdc_pkg::ADDR_RIGHT: next_hrdata = {14'h0, right_w};
                default:             next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_CAL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        cal_active_out |-> out_zero)
        else $error("output not zero during calibration");
    AST_CAL_END: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(cal_active_out) |->
        $past(cal_cnt) == sdc_pkg::FRM_W'(sdc_pkg::CAL_FRAMES - 1))
        else $error("calibration ended at wrong count");
    AST_CAL_STAY: assert property (@(posedge hclk) disable iff (!hresetn)
        !cal_active_out |=> !cal_active_out)
        else $error("calibration restarted without reset");
    AST_SOFT: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cmute[1] |=> out_soft_mute)
        else $error("soft mute late");
    AST_UNMUTE: assert property (@(posedge hclk) disable iff (!hresetn)
        !s_cmute[1] |=> !out_soft_mute)
        else $error("soft mute stuck");
    AST_DEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(out_deep_mute) |->
        $past(zero_cnt) == sdc_pkg::FRM_W'(sdc_pkg::MUTE_FRAMES - 1))
        else $error("deep mute at wrong count");
    AST_DEEP_REL: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_tick && !zero_frame |=> !out_deep_mute)
        else $error("deep mute not released");
    AST_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
        take |-> $past(serial_bit_clk, 2) == (mode != sdc_pkg::MODE_DSP) &&
        $past(serial_bit_clk, 3) == (mode == sdc_pkg::MODE_DSP))
        else $error("wrong sampling edge");
    AST_FILT: assert property (@(posedge hclk) disable iff (!hresetn)
        filt_run && !s_cks[1] && $past(filt_run) |=>
        filter_clk_out != $past(filter_clk_out))
        else $error("filter clock not toggling");
endmodule
`default_nettype wire

// ---- verif/sdc_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdc_src (
    input  wire logic        hclk,
    input  wire logic        run,
    input  wire logic        fast,
    input  wire logic [1:0]  mode,
    input  wire logic        short16,
    input  wire logic [17:0] left_word,
    input  wire logic [17:0] right_word,
    output logic             serial_bit_clk,
    output logic             channel_frame_clk,
    output logic             serial_sample_in
);
    logic [2:0]  cnt;
    logic [4:0]  idx;
    logic        chan;
    logic        fast_frm;
    logic        pad;
    logic [4:0]  off;
    logic [4:0]  nb;
    logic [4:0]  k;
    logic [17:0] w;
    logic        last;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cnt      = 3'h0;
        idx      = 5'h00;
        chan     = 1'b0;
        fast_frm = 1'b0;
        pad      = 1'b0;
    end
    // Word placement in each channel slot
    assign off = short16 ? 5'h00 : (mode == sdc_pkg::MODE_DAC16) ? 5'h08 :
                 (mode == sdc_pkg::MODE_DAC18) ? 5'h06 : 5'h00;
    assign nb  = (short16 || mode == sdc_pkg::MODE_DAC16) ? 5'h10 : 5'h12;
    assign w    = chan ? right_word : left_word;
    assign k    = idx - off;
    assign last = (idx == (short16 ? 5'h0F : 5'h17));
    // Link clocks divided from the master clock, still when idle
    // Fast zero frames: three bit clocks per channel
    assign serial_bit_clk = !run ? 1'b0 : fast ? cnt[0] :
        ((cnt >= 3'h4) != (mode == sdc_pkg::MODE_DSP));
    assign channel_frame_clk = (run && !fast) ?
        (chan == (mode == sdc_pkg::MODE_I2S)) : fast_frm;
    // Unused slots carry a toggling pattern
    assign serial_sample_in = !run ? pad : fast ? 1'b0 :
        (idx >= off && idx < off + nb) ? w[5'h11 - k] : pad;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        pad <= ~pad;
        if (!run || fast) begin
            idx      <= 5'h00;
            chan     <= 1'b0;
            cnt      <= (fast && cnt != 3'h5) ? cnt + 3'h1 : 3'h0;
            fast_frm <= (fast && cnt == 3'h5) ? ~fast_frm : fast_frm;
        end else begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) begin
                idx  <= last ? 5'h00 : idx + 5'h01;
                chan <= last ? ~chan : chan;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/sdc_top_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdc_top_test;
    typedef struct packed {
        logic [1:0]  mode;
        logic        short16;
        logic [17:0] lw;
        logic [17:0] rw;
    } sdc_row_t;
    localparam int LIMIT = 98000;
    logic        hclk, hresetn, clk_ratio_sel, factory_test_pin, run, fast;
    logic        serial_bit_clk, channel_frame_clk, serial_sample_in;
    logic        cal_mute_in, comparator_in, mute_force, hsel, hwrite;
    logic        hreadyout, hresp, filter_clk_out, cal_active_out;
    logic        comparator_out, out_zero, out_soft_mute, out_deep_mute;
    logic        sample_valid, short16;
    logic [1:0]  mode, htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [17:0] sample_left, sample_right, lw, rw;
    int          mismatches, n_checks, cycles, flen, fc, sv;
    sdc_row_t    rows [8] = '{
        '{2'h0, 1'b0, 18'h2468C, 18'h20004},
        '{2'h1, 1'b0, 18'h3FFFF, 18'h00001},
        '{2'h2, 1'b0, 18'h20001, 18'h1FFFE},
        '{2'h3, 1'b0, 18'h12345, 18'h2CDEF},
        '{2'h0, 1'b1, 18'h3FFFC, 18'h00004},
        '{2'h2, 1'b1, 18'h2AAA8, 18'h15554},
        '{2'h3, 1'b1, 18'h10004, 18'h3FFF0},
        '{2'h3, 1'b0, 18'h24680, 18'h1357C}};
    ////////////////////////////////////////////////////////////////////////
    assign cal_mute_in = cal_active_out | mute_force;
    always #50 hclk = ~hclk;
    sdc_top u_sdc_top (.hclk(hclk), .hresetn(hresetn),
        .clk_ratio_sel(clk_ratio_sel), .fmt_sel_lo(mode[0]),
        .fmt_sel_hi(mode[1]), .factory_test_pin(factory_test_pin),
        .serial_bit_clk(serial_bit_clk), .channel_frame_clk(channel_frame_clk),
        .serial_sample_in(serial_sample_in), .cal_mute_in(cal_mute_in),
        .comparator_in(comparator_in), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .filter_clk_out(filter_clk_out),
        .cal_active_out(cal_active_out), .comparator_out(comparator_out),
        .out_zero(out_zero), .out_soft_mute(out_soft_mute),
        .out_deep_mute(out_deep_mute), .sample_left(sample_left),
        .sample_right(sample_right), .sample_valid(sample_valid));
    sdc_src u_sdc_src (.hclk(hclk), .run(run), .fast(fast), .mode(mode),
        .short16(short16), .left_word(lw), .right_word(rw),
        .serial_bit_clk(serial_bit_clk), .channel_frame_clk(channel_frame_clk),
        .serial_sample_in(serial_sample_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    // Single word transfer, address then data phase
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= sdc_pkg::HTRANS_NSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk_flag("hresp", 1'b0, hresp);
    endtask
    // Filter clock rises and valid pulses over one frame
    task automatic count_frame(input int n);
        logic p;
        fc = 0;
        sv = 0;
        p  = filter_clk_out;
        repeat (n) begin
            @(posedge hclk);
            if (filter_clk_out === 1'b1 && p === 1'b0) fc++;
            if (sample_valid === 1'b1) sv++;
            p = filter_clk_out;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        hclk = 1'b0; hresetn = 1'b0; clk_ratio_sel = 1'b1; mode = 2'h0;
        factory_test_pin = 1'b0; run = 1'b0; fast = 1'b0; short16 = 1'b0;
        comparator_in = 1'b0; mute_force = 1'b0; hsel = 1'b0; hwrite = 1'b0;
        htrans = 2'h0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
        lw = 18'h0; rw = 18'h0; mismatches = 0; n_checks = 0; cycles = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        run     <= 1'b1;
        foreach (rows[i]) begin
            mode          <= rows[i].mode;
            short16       <= rows[i].short16;
            clk_ratio_sel <= !rows[i].short16;
            lw            <= rows[i].lw;
            rw            <= rows[i].rw;
            flen = rows[i].short16 ? 256 : 384;
            repeat (3 * flen) @(posedge hclk);
            chk_word("left", {14'h0, rows[i].lw}, {14'h0, sample_left});
            chk_word("right", {14'h0, rows[i].rw}, {14'h0, sample_right});
            bus(1'b0, sdc_pkg::ADDR_LEFT, 32'h0, rd);
            chk_word("left_reg", {14'h0, rows[i].lw}, {14'h0, rd[17:0]});
            bus(1'b0, sdc_pkg::ADDR_RIGHT, 32'h0, rd);
            chk_word("right_reg", {14'h0, rows[i].rw}, {14'h0, rd[17:0]});
            bus(1'b0, sdc_pkg::ADDR_STATUS, 32'h0, rd);
            chk_word("mode", {30'h0, rows[i].mode}, {30'h0, rd[7:6]});
            count_frame(flen);
            chk_word("filter_rises", 32'h80, fc);
            chk_word("valid_count", 32'h1, sv);
        end
        // Writes are ignored and an unmapped place reads zero
        bus(1'b1, sdc_pkg::ADDR_LEFT, 32'hFFFFFFFF, rd);
        bus(1'b0, sdc_pkg::ADDR_LEFT, 32'h0, rd);
        chk_word("left_kept", {14'h0, rows[7].lw}, {14'h0, rd[17:0]});
        bus(1'b0, 8'h0C, 32'h0, rd);
        chk_word("unmapped", 32'h0, rd);
        comparator_in <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_flag("comparator", 1'b1, comparator_out);
        // Reset in mid-run, then fast zero frames through calibration
        hresetn <= 1'b0;
        fast    <= 1'b1;
        mode    <= 2'h0;
        repeat (2) @(posedge hclk);
        chk_flag("cal_in_reset", 1'b1, cal_active_out);
        chk_flag("zero_in_reset", 1'b1, out_zero);
        chk_word("left_cleared", 32'h0, {14'h0, sample_left});
        hresetn <= 1'b1;
        repeat (1000 * 12) @(posedge hclk);
        chk_flag("cal_running", 1'b1, cal_active_out);
        chk_flag("zero_cal", 1'b1, out_zero);
        repeat (100 * 12) @(posedge hclk);
        chk_flag("cal_done", 1'b0, cal_active_out);
        chk_flag("unmuted", 1'b0, out_soft_mute);
        mute_force <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_flag("soft_mute", 1'b1, out_soft_mute);
        mute_force <= 1'b0;
        repeat (4) @(posedge hclk);
        chk_flag("soft_unmute", 1'b0, out_soft_mute);
        repeat (2900 * 12) @(posedge hclk);
        chk_flag("deep_early", 1'b0, out_deep_mute);
        chk_flag("zero_frames", 1'b1, out_zero);
        repeat (1200 * 12) @(posedge hclk);
        chk_flag("deep_on", 1'b1, out_deep_mute);
        // Non-zero data releases the deep mute
        fast          <= 1'b0;
        short16       <= 1'b1;
        clk_ratio_sel <= 1'b0;
        lw            <= 18'h00004;
        rw            <= 18'h3FFFC;
        repeat (3 * 256) @(posedge hclk);
        chk_flag("deep_off", 1'b0, out_deep_mute);
        repeat (40 * 256) @(posedge hclk);
        chk_flag("zero_off", 1'b0, out_zero);
        close_out();
    end
endmodule
`default_nettype wire
